//--- verilog/rsq_pkg.sv
// constants shared by the rail sequencer and its delay timer
package rsq_pkg;
    localparam int NUM_RAILS = 12;
    localparam int NUM_CTL   = 6;
    localparam int NUM_STAT  = 4;
    localparam int RAIL_FIRST_BUCK_RAIL = 0;
    localparam int RAIL_AON   = 6;

    // timing: 20 MHz system clock, delays are programmed in whole ms
    localparam int CLK_PERIOD_NS = 50;
    localparam int ONE_MS_NS     = 1000000;
    localparam int CYCLES_PER_MS = ONE_MS_NS / CLK_PERIOD_NS;
    localparam int MS_CNT_W      = 16;
    localparam int DLY_W         = 7;

    localparam logic [6:0] STAT1_DLY_MIN_MS = 7'h00;
    localparam logic [6:0] STAT1_DLY_MAX_MS = 7'h0f;
    localparam logic [6:0] STAT3_DLY_MIN_MS = 7'h05;
    localparam logic [6:0] STAT_DLY_MIN_MS  = 7'h00;
    localparam logic [6:0] STAT_DLY_MAX_MS  = 7'h64;

    // register byte offsets
    localparam logic [7:0] ADDR_SW_EN    = 8'h00;
    localparam logic [7:0] ADDR_CTRL     = 8'h04;
    localparam logic [7:0] ADDR_VCODE    = 8'h08;
    localparam logic [7:0] ADDR_STAT_CFG = 8'h0c;
    localparam logic [7:0] ADDR_PG_STAT  = 8'h10;
    localparam logic [7:0] ADDR_EN_STAT  = 8'h14;
    localparam logic [7:0] ADDR_STAT_DLY = 8'h18;
    localparam logic [3:0] ADDR_MBR_HI   = 4'h2;
    localparam logic [1:0] ADDR_RCFG_HI  = 2'h1;

    // field positions
    localparam int CTRL_SLP3_BIT  = 0;
    localparam int CTRL_SLP6_BIT  = 1;
    localparam int CTRL_DECAY_BIT = 2;
    localparam int CTRL_AON_BIT   = 3;
    localparam int VC_NORM_LSB    = 0;
    localparam int VC_SLP_LSB     = 8;
    localparam int SCFG_MODE_LSB  = 0;
    localparam int SCFG_LVL_LSB   = 4;
    localparam int EN_STAT_LSB    = 0;
    localparam int EN_GOUT_LSB    = 12;
    localparam int EN_SLEEP_BIT   = 16;
    localparam int RCFG_CTL_LSB   = 0;
    localparam int RCFG_PG_LSB    = 4;
    localparam int RCFG_UP_LSB    = 8;
    localparam int RCFG_DN_LSB    = 16;
    localparam int SDLY_STRIDE    = 8;

    // reset values
    localparam logic [31:0] SW_EN_RST    = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0008;
    localparam logic [31:0] VCODE_RST    = 32'h0000_0000;
    localparam logic [31:0] STAT_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] STAT_DLY_RST = 32'h0000_0500;
    localparam logic [31:0] MBR_RST      = 32'h0000_0000;
    localparam logic [31:0] RCFG_RST     = 32'h0000_00f0;
    localparam logic [3:0]  PG_SRC_NONE  = 4'hf;

    localparam logic [1:0] RSP_OKAY   = 2'h0;
    localparam logic [1:0] RSP_DECERR = 2'h3;
endpackage : rsq_pkg

//--- verilog/rsq_delay_timer.sv
// restartable millisecond delay timer
`timescale 1ns/1ps
`default_nettype none
module rsq_delay_timer #(
    parameter int CYC_PER_MS = rsq_pkg::CYCLES_PER_MS
) (
    input  wire logic                     clk_sys_in,
    input  wire logic                     rstn_in,
    input  wire logic                     cond_in,
    input  wire logic [rsq_pkg::DLY_W-1:0] delay_ms_in,
    output logic                          done_out
);
    import rsq_pkg::*;

    logic [MS_CNT_W-1:0] sub_cnt;
    logic [DLY_W-1:0]    ms_cnt;

    localparam logic [MS_CNT_W-1:0] SUB_LAST = MS_CNT_W'(CYC_PER_MS - 1);

    // losing the condition throws away partial progress
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sub_cnt  <= '0;
            ms_cnt   <= '0;
            done_out <= 1'b0;
        end else if (!cond_in) begin
            sub_cnt  <= '0;
            ms_cnt   <= '0;
            done_out <= 1'b0;
        end else if (!done_out) begin
            if (ms_cnt >= delay_ms_in) begin
                done_out <= 1'b1;
            end else if (sub_cnt == SUB_LAST) begin
                sub_cnt <= '0;
                ms_cnt  <= ms_cnt + 1'b1;
            end else begin
                sub_cnt <= sub_cnt + 1'b1;
            end
        end
    end
endmodule : rsq_delay_timer
`default_nettype wire

//--- verilog/rsq_rail_seq.sv
// rail enable sequencer and power-good tree with an Avalon-MM slave
//
// Summary of operation
// - any rail's good may join any tree
// - first status output delay 0 to 15 ms
// - third status output delay 5 to 100 ms
// - second, fourth status delay 0 to 100 ms
// - four status pins plus readable good register
// - status pins may be software-driven outputs
// - enable by pin, prior good, or software
// - programmable delay from trigger to enable
// - software may enable any rail, or disable one that no pin or good request holds on
// - six control pins, rail picks one group
// - twelve rails: six buck, three linear, three switch
// - third, sixth control pins may be sleep
// - sleep low selects first buck sleep code
// - rail may follow a prior rail's good
// - good chaining combines with pin groups
// - always-on linear rail survives emergency shutdown
// - early pin waits for prerequisite good
// - independent power-down delay per rail
// - sleep entry decays or slews by select
`timescale 1ns/1ps
`default_nettype none
module rsq_rail_seq #(
    parameter int CYC_PER_MS = rsq_pkg::CYCLES_PER_MS
) (
    input  wire logic                           clk_sys_in,
    input  wire logic                           rstn_in,
    input  wire logic [7:0]                     avs_address_in,
    input  wire logic                           avs_read_in,
    input  wire logic                           avs_write_in,
    input  wire logic [31:0]                    avs_writedata_in,
    input  wire logic [3:0]                     avs_byteenable_in,
    output logic      [31:0]                    avs_readdata_out,
    output logic                                avs_waitrequest_out,
    output logic      [1:0]                     avs_response_out,
    input  wire logic [rsq_pkg::NUM_CTL-1:0]    group_control_input_in,
    input  wire logic [rsq_pkg::NUM_RAILS-1:0]  rail_good_signal_in,
    input  wire logic                           emerg_shdn_in,
    output logic      [rsq_pkg::NUM_RAILS-1:0]  rail_en_out,
    output logic      [rsq_pkg::NUM_STAT-1:0]   status_output_out,
    output logic      [6:0]                     first_buck_rail_vcode_out,
    output logic                                first_buck_rail_sleep_out,
    output logic                                decay_select_out
);
    import rsq_pkg::*;

    // ---------------- register storage
    logic [31:0] sw_en;
    logic [31:0] ctrl;
    logic [31:0] vcode;
    logic [31:0] stat_cfg;
    logic [31:0] stat_dly;
    logic [31:0] mbr  [NUM_STAT];
    logic [31:0] rcfg [NUM_RAILS];

    // ---------------- helpers
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be

    function automatic logic [6:0] clamp_dly(input logic [6:0] v,
                                             input logic [6:0] lo,
                                             input logic [6:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : clamp_dly

    function automatic logic is_mbr(input logic [7:0] a);
        return (a[7:4] == ADDR_MBR_HI);
    endfunction : is_mbr

    function automatic logic is_rcfg(input logic [7:0] a);
        return (a[7:6] == ADDR_RCFG_HI) && (a[5:2] < 4'(NUM_RAILS));
    endfunction : is_rcfg

    // ---------------- bus handshake
    // one wait cycle: decode and capture read data, then answer;
    // the write lands on the same edge the master sees waitrequest low
    logic        bus_req;
    logic        bus_take;
    logic [31:0] next_rdata;
    logic        next_hit;

    assign bus_req  = (avs_read_in ^ avs_write_in);
    assign bus_take = bus_req && !avs_waitrequest_out;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            avs_waitrequest_out <= 1'b1;
        end else if (bus_req && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            avs_readdata_out <= 32'h0000_0000;
            avs_response_out <= RSP_OKAY;
        end else if (bus_req && avs_waitrequest_out) begin
            avs_readdata_out <= avs_read_in ? next_rdata : 32'h0000_0000;
            avs_response_out <= next_hit ? RSP_OKAY : RSP_DECERR;
        end
    end

    // ---------------- read decode
    logic [31:0] pg_stat;
    logic [31:0] en_stat;
    logic        sleep_req;

    // per-rail good is visible to software as well as on the pins
    assign pg_stat = {20'h00000, rail_good_signal_in};
    always_comb begin
        en_stat = 32'h0000_0000;
        en_stat[EN_STAT_LSB +: NUM_RAILS] = rail_en_out;
        en_stat[EN_GOUT_LSB +: NUM_STAT]  = status_output_out;
        en_stat[EN_SLEEP_BIT]             = first_buck_rail_sleep_out;
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_hit   = 1'b1;
        if (avs_address_in == ADDR_SW_EN) begin
            next_rdata = sw_en;
        end else if (avs_address_in == ADDR_CTRL) begin
            next_rdata = ctrl;
        end else if (avs_address_in == ADDR_VCODE) begin
            next_rdata = vcode;
        end else if (avs_address_in == ADDR_STAT_CFG) begin
            next_rdata = stat_cfg;
        end else if (avs_address_in == ADDR_PG_STAT) begin
            next_rdata = pg_stat;
        end else if (avs_address_in == ADDR_EN_STAT) begin
            next_rdata = en_stat;
        end else if (avs_address_in == ADDR_STAT_DLY) begin
            next_rdata = stat_dly;
        end else if (is_mbr(avs_address_in)) begin
            next_rdata = mbr[avs_address_in[3:2]];
        end else if (is_rcfg(avs_address_in)) begin
            next_rdata = rcfg[avs_address_in[5:2]];
        end else begin
            next_hit = 1'b0;
        end
    end

    // ---------------- register writes
    logic wr_take;
    assign wr_take = bus_take && avs_write_in;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sw_en    <= SW_EN_RST;
            ctrl     <= CTRL_RST;
            vcode    <= VCODE_RST;
            stat_cfg <= STAT_CFG_RST;
            stat_dly <= STAT_DLY_RST;
        end else if (wr_take) begin
            if (avs_address_in == ADDR_SW_EN) begin
                // software path to turn any rail on, or off when no pin or good request holds it on
                sw_en <= merge_be(sw_en, avs_writedata_in,
                                  avs_byteenable_in) & 32'h0000_0fff;
            end else if (avs_address_in == ADDR_CTRL) begin
                ctrl <= merge_be(ctrl, avs_writedata_in,
                                 avs_byteenable_in) & 32'h0000_000f;
            end else if (avs_address_in == ADDR_VCODE) begin
                vcode <= merge_be(vcode, avs_writedata_in,
                                  avs_byteenable_in) & 32'h0000_7f7f;
            end else if (avs_address_in == ADDR_STAT_CFG) begin
                stat_cfg <= merge_be(stat_cfg, avs_writedata_in,
                                     avs_byteenable_in) & 32'h0000_00ff;
            end else if (avs_address_in == ADDR_STAT_DLY) begin
                stat_dly <= merge_be(stat_dly, avs_writedata_in,
                                     avs_byteenable_in) & 32'h7f7f_7f7f;
            end
        end
    end

    // tree membership: any rail into any tree
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int t = 0; t < NUM_STAT; t++) begin
                mbr[t] <= MBR_RST;
            end
        end else if (wr_take && is_mbr(avs_address_in)) begin
            mbr[avs_address_in[3:2]] <=
                merge_be(mbr[avs_address_in[3:2]], avs_writedata_in,
                         avs_byteenable_in) & 32'h0000_0fff;
        end
    end

    // each of twelve rails picks one pin group
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int r = 0; r < NUM_RAILS; r++) begin
                rcfg[r] <= RCFG_RST;
            end
        end else if (wr_take && is_rcfg(avs_address_in)) begin
            rcfg[avs_address_in[5:2]] <=
                merge_be(rcfg[avs_address_in[5:2]], avs_writedata_in,
                         avs_byteenable_in) & 32'h007f_7ff7;
        end
    end

    // ---------------- control pins: group enable or sleep
    logic [NUM_CTL-1:0] grp_level;

    // a pin used as sleep no longer acts as a group enable
    always_comb begin
        grp_level    = group_control_input_in;
        grp_level[2] = group_control_input_in[2] && !ctrl[CTRL_SLP3_BIT];
        grp_level[5] = group_control_input_in[5] && !ctrl[CTRL_SLP6_BIT];
    end

    assign sleep_req = (ctrl[CTRL_SLP3_BIT] && !group_control_input_in[2])
                    || (ctrl[CTRL_SLP6_BIT] && !group_control_input_in[5]);

    // ---------------- per-rail enable request
    logic [NUM_RAILS-1:0] rail_req;
    logic [NUM_RAILS-1:0] up_cond;
    logic [NUM_RAILS-1:0] dn_cond;
    logic [NUM_RAILS-1:0] up_done;
    logic [NUM_RAILS-1:0] dn_done;
    logic [NUM_RAILS-1:0] aon_mask;

    always_comb begin
        aon_mask = '0;
        aon_mask[RAIL_AON] = ctrl[CTRL_AON_BIT];
    end

    always_comb begin
        logic [2:0] csel;
        logic [3:0] psel;
        logic       ctl_met;
        logic       pg_met;
        logic       auto_on;
        csel    = 3'h0;
        psel    = PG_SRC_NONE;
        ctl_met = 1'b0;
        pg_met  = 1'b0;
        auto_on = 1'b0;
        rail_req = '0;
        for (int r = 0; r < NUM_RAILS; r++) begin
            csel = rcfg[r][RCFG_CTL_LSB +: 3];
            psel = rcfg[r][RCFG_PG_LSB +: 4];
            ctl_met = (csel == 3'h0) || (csel > 3'(NUM_CTL)) ? 1'b1
                    : grp_level[csel - 3'h1];
            // a pin that rises early still waits for the prior good
            pg_met  = (psel >= 4'(NUM_RAILS)) ? 1'b1
                    : rail_good_signal_in[psel];
            auto_on = ((csel != 3'h0) && (csel <= 3'(NUM_CTL)))
                   || (psel < 4'(NUM_RAILS));
            // pin, chained good, or software, and pin with good
            rail_req[r] = sw_en[r]
                       || (auto_on && ctl_met && pg_met);
        end
    end

    // emergency shutdown blocks power-up except the always-on rail
    assign up_cond = rail_req & (~{NUM_RAILS{emerg_shdn_in}} | aon_mask);
    assign dn_cond = ~rail_req;

    // separate power-up and power-down delay per rail
    for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
        rsq_delay_timer #(
            .CYC_PER_MS (CYC_PER_MS)
        ) u_up (
            .clk_sys_in  (clk_sys_in),
            .rstn_in     (rstn_in),
            .cond_in     (up_cond[g]),
            .delay_ms_in (rcfg[g][RCFG_UP_LSB +: DLY_W]),
            .done_out    (up_done[g])
        );
        rsq_delay_timer #(
            .CYC_PER_MS (CYC_PER_MS)
        ) u_dn (
            .clk_sys_in  (clk_sys_in),
            .rstn_in     (rstn_in),
            .cond_in     (dn_cond[g]),
            .delay_ms_in (rcfg[g][RCFG_DN_LSB +: DLY_W]),
            .done_out    (dn_done[g])
        );
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rail_en_out <= '0;
        end else begin
            for (int r = 0; r < NUM_RAILS; r++) begin
                if (emerg_shdn_in && !aon_mask[r]) begin
                    rail_en_out[r] <= 1'b0;
                end else if (up_done[r]) begin
                    rail_en_out[r] <= 1'b1;
                end else if (dn_done[r]) begin
                    rail_en_out[r] <= 1'b0;
                end
            end
        end
    end

    // ---------------- first buck sleep control
    // the regulator holds the selected code; decay only on the way down
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            first_buck_rail_vcode_out <= 7'h00;
            first_buck_rail_sleep_out <= 1'b0;
            decay_select_out <= 1'b0;
        end else begin
            first_buck_rail_sleep_out <= sleep_req;
            first_buck_rail_vcode_out <= sleep_req ? vcode[VC_SLP_LSB +: 7]
                                         : vcode[VC_NORM_LSB +: 7];
            decay_select_out <= sleep_req && ctrl[CTRL_DECAY_BIT];
        end
    end

    // ---------------- power-good trees
    logic [NUM_STAT-1:0] tree_all;
    logic [NUM_STAT-1:0] tree_done;
    logic [6:0]          tree_dly [NUM_STAT];

    always_comb begin
        for (int t = 0; t < NUM_STAT; t++) begin
            // an empty tree never reports good
            tree_all[t] = !emerg_shdn_in && (|mbr[t][NUM_RAILS-1:0])
                && (&(rail_good_signal_in | ~mbr[t][NUM_RAILS-1:0]));
        end
    end

    // out-of-range settings are clamped into the legal window
    assign tree_dly[0] = clamp_dly(stat_dly[0*SDLY_STRIDE +: 7],
                                   STAT1_DLY_MIN_MS,
                                   STAT1_DLY_MAX_MS);
    assign tree_dly[1] = clamp_dly(stat_dly[1*SDLY_STRIDE +: 7],
                                   STAT_DLY_MIN_MS,
                                   STAT_DLY_MAX_MS);
    assign tree_dly[2] = clamp_dly(stat_dly[2*SDLY_STRIDE +: 7],
                                   STAT3_DLY_MIN_MS,
                                   STAT_DLY_MAX_MS);
    assign tree_dly[3] = clamp_dly(stat_dly[3*SDLY_STRIDE +: 7],
                                   STAT_DLY_MIN_MS,
                                   STAT_DLY_MAX_MS);

    for (genvar g = 0; g < NUM_STAT; g++) begin : g_tree
        rsq_delay_timer #(
            .CYC_PER_MS (CYC_PER_MS)
        ) u_pg (
            .clk_sys_in  (clk_sys_in),
            .rstn_in     (rstn_in),
            .cond_in     (tree_all[g]),
            .delay_ms_in (tree_dly[g]),
            .done_out    (tree_done[g])
        );
    end

    // drop is gated by tree_all directly, so it skips the delay
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_output_out <= '0;
        end else begin
            for (int t = 0; t < NUM_STAT; t++) begin
                if (stat_cfg[SCFG_MODE_LSB + t]) begin
                    // shutdown pulls software-driven pins low as well
                    status_output_out[t] <= !emerg_shdn_in
                        && stat_cfg[SCFG_LVL_LSB + t];
                end else begin
                    status_output_out[t] <= tree_all[t]
                                         && tree_done[t];
                end
            end
        end
    end
endmodule : rsq_rail_seq
`default_nettype wire

//--- verif/rsq_rail_seq_chk.sv
// checker for the rail sequencer's bus answers and safety outputs
`timescale 1ns/1ps
`default_nettype none
module rsq_rail_seq_chk (
    input wire logic        clk_sys_in,
    input wire logic        rstn_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic [1:0]  avs_response_out,
    input wire logic [5:0]  group_control_input_in,
    input wire logic        emerg_shdn_in,
    input wire logic [11:0] rail_en_out,
    input wire logic [3:0]  status_output_out,
    input wire logic        first_buck_rail_sleep_out,
    input wire logic        decay_select_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    a_wait_once: assert property (
        (avs_read_in ^ avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("no answer after request");
    a_wait_pulse: assert property (
        !avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    a_rdata_held: assert property (
        avs_waitrequest_out && $past(avs_waitrequest_out)
        |-> $stable(avs_readdata_out)) else $error("read data moved");
    a_decerr_zero: assert property (
        !avs_waitrequest_out && avs_response_out == 2'h3
        |-> avs_readdata_out == 32'h0) else $error("error read not zero");
    a_emerg_rails: assert property (
        emerg_shdn_in |=> (rail_en_out & 12'hfbf) == 12'h000)
        else $error("rail left on in shutdown");
    a_emerg_status: assert property (
        emerg_shdn_in |=> status_output_out == 4'h0)
        else $error("status left on in shutdown");
    a_decay_sleep: assert property (
        decay_select_out |-> first_buck_rail_sleep_out) else $error("decay outside sleep");
    a_sleep_pin: assert property (
        $rose(first_buck_rail_sleep_out) |-> $past(!group_control_input_in[2]
        || !group_control_input_in[5])) else $error("sleep without low pin");
endmodule : rsq_rail_seq_chk
bind rsq_rail_seq rsq_rail_seq_chk rsq_rail_seq_chk_i (.clk_sys_in,
    .rstn_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
    .avs_waitrequest_out, .avs_response_out, .group_control_input_in,
    .emerg_shdn_in, .rail_en_out, .status_output_out, .first_buck_rail_sleep_out,
    .decay_select_out);
`default_nettype wire

//--- verif/rsq_rail_model.sv
// rail stand-in: good follows enable after a lag, or fails on demand
`timescale 1ns/1ps
`default_nettype none
module rsq_rail_model #(
    parameter int LAG = 3
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rstn_in,
    input  wire logic [11:0] rail_en_in,
    input  wire logic [11:0] fail_in,
    output logic      [11:0] good_out
);
    logic [LAG-1:0][11:0] hist;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hist <= '0;
        end else begin
            hist <= {hist[LAG-2:0], rail_en_in};
        end
    end
    // good drops at once on disable, so a tree never sees stale good
    assign good_out = hist[LAG-1] & rail_en_in & ~fail_in;
endmodule : rsq_rail_model
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the rail sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rsq_pkg::*;
    localparam int CPM = 10;
    logic clk_sys_in, rstn_in, avs_read_in, avs_write_in, emerg_shdn_in;
    logic [7:0]  avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    logic [3:0]  avs_byteenable_in, status_output_out;
    logic [1:0]  avs_response_out, r;
    logic        avs_waitrequest_out, first_buck_rail_sleep_out, decay_select_out;
    logic [5:0]  group_control_input_in;
    logic [11:0] rail_good_signal_in, rail_en_out, fail;
    logic [6:0]  first_buck_rail_vcode_out;
    wire logic [15:0] obs = {status_output_out, rail_en_out};
    int miscompares, n_tests, n;
    rsq_rail_seq #(.CYC_PER_MS(CPM)) rsq_rail_seq_i (.clk_sys_in, .rstn_in,
        .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
        .avs_response_out, .group_control_input_in, .rail_good_signal_in,
        .emerg_shdn_in, .rail_en_out, .status_output_out, .first_buck_rail_vcode_out,
        .first_buck_rail_sleep_out, .decay_select_out);
    rsq_rail_model rsq_rail_model_i (.clk_sys_in, .rstn_in,
        .rail_en_in(rail_en_out), .fail_in(fail),
        .good_out(rail_good_signal_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    task end_of_test;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask : chk
    // one transfer; entered just after an edge, values taken at the answer
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        do begin
            @(posedge clk_sys_in);
            i++;
        end while (avs_waitrequest_out !== 1'b0 && i < 50);
        q = avs_readdata_out;
        r = avs_response_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (i >= 50) begin
            miscompares++;
            end_of_test();
        end
        // one idle edge, so a following call never re-drives a strobe
        @(posedge clk_sys_in);
    endtask : bus
    // counts edges until obs[k] shows lv; a change is seen one edge late
    task wt(input int k, input logic lv);
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (obs[k] !== lv && n < 400);
        if (n >= 400) begin
            miscompares++;
            end_of_test();
        end
    endtask : wt
    initial begin
        {rstn_in, avs_read_in, avs_write_in, emerg_shdn_in} = 4'h0;
        {avs_address_in, avs_writedata_in, group_control_input_in} = '0;
        avs_byteenable_in = 4'hf;
        fail = 12'h000;
        repeat (8) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        @(posedge clk_sys_in);
        bus(0, ADDR_CTRL, 0);
        chk(CTRL_RST, q);
        bus(0, ADDR_STAT_DLY, 0);
        chk(STAT_DLY_RST, q);
        bus(0, 8'h40, 0);
        chk(RCFG_RST, q);
        bus(0, 8'h1c, 0);
        chk(32'h0, q);
        chk(32'(RSP_DECERR), 32'(r));
        bus(1, 8'h40, 32'h0001_02f1);
        bus(1, 8'h44, 32'h0000_0000);
        bus(1, 8'h48, 32'h0000_0002);
        bus(1, ADDR_STAT_DLY, 32'h0000_0503);
        bus(1, 8'h20, 32'h0000_0007);
        group_control_input_in <= 6'h02;
        repeat (30) @(posedge clk_sys_in);
        chk(32'h0, 32'(rail_en_out[2]));
        group_control_input_in <= 6'h03;
        wt(0, 1);
        chk(2 * CPM + 3, n);
        wt(2, 1);
        wt(1, 1);
        chk(32'h1, 32'(rail_en_out[2]));
        wt(12, 1);
        fail <= 12'h002;
        wt(12, 0);
        chk(2, n);
        fail <= 12'h000;
        repeat (15) @(posedge clk_sys_in);
        fail <= 12'h002;
        @(posedge clk_sys_in);
        fail <= 12'h000;
        wt(12, 1);
        chk(3 * CPM + 3, n);
        bus(0, ADDR_PG_STAT, 0);
        chk(32'h007, q);
        bus(1, ADDR_SW_EN, 32'h0000_0240);
        wt(9, 1);
        chk(32'h1, 32'(rail_en_out[6]));
        bus(1, ADDR_STAT_CFG, 32'h0000_0022);
        wt(13, 1);
        bus(0, ADDR_EN_STAT, 0);
        chk(32'h0000_3247, q);
        bus(1, ADDR_STAT_CFG, 32'h0);
        bus(1, ADDR_VCODE, 32'h0000_152a);
        bus(1, ADDR_CTRL, 32'h0000_000d);
        repeat (3) @(posedge clk_sys_in);
        chk(32'h15, 32'(first_buck_rail_vcode_out));
        chk(32'h3, 32'({first_buck_rail_sleep_out, decay_select_out}));
        group_control_input_in <= 6'h07;
        repeat (3) @(posedge clk_sys_in);
        chk(32'h2a, 32'({first_buck_rail_sleep_out, first_buck_rail_vcode_out}));
        group_control_input_in <= 6'h06;
        wt(0, 0);
        chk(CPM + 3, n);
        emerg_shdn_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        chk(32'h040, 32'(rail_en_out));
        emerg_shdn_in <= 1'b0;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
